// >>> verilog/opc_consts.svh
// Operation
// RULE1: capture fires on each rising edge of the slow oscillator divided by 128.
// RULE2: interrupt request raised by capture edge or counter overflow, each enabled apart.
// RULE3: counter overflow sets the overflow flag to one.
// RULE4: capture edge sets capture_a_flag to one.
// RULE5: capture loads current register and moves old current value into previous register; code moves it only when buf_en is set.
// RULE6: fast oscillator clock selectable as counter count source.
// RULE7: separate enables for capture and overflow interrupts; capture edge configurable rising.
// RULE8: counter counts per source tick, wraps at full scale with overflow, runs across captures; code clears it on capture when clr_on_cap is set.
`ifndef OPC_CONSTS_SVH
`define OPC_CONSTS_SVH

`define OPC_ADDR_W 8
`define OPC_ADDR_CTRL 8'h00
`define OPC_ADDR_STATUS 8'h04
`define OPC_ADDR_IRQ_EN 8'h08
`define OPC_ADDR_COUNT 8'h0C
`define OPC_ADDR_CAP_CUR 8'h10
`define OPC_ADDR_CAP_PREV 8'h14
`define OPC_ADDR_CAP_NUM 8'h18
`define OPC_ADDR_OVF_SNAP 8'h1C

`define OPC_CTRL_W 6
`define OPC_CTRL_RST 6'h00
`define OPC_EVT_W 2
`define OPC_EVT_RST 2'h0
`define OPC_BIT_CAP 0
`define OPC_BIT_OVF 1

`define OPC_CNT_W 16
`define OPC_SLOW_DIV 128
`define OPC_PRE_W 3

`endif

// >>> verilog/opc_pkg.sv
package opc_pkg;

  // control register layout, lsb last
  typedef struct packed {
    logic buf_en;
    logic clr_on_cap;
    logic edge_fall;
    logic [1:0] src;
    logic run;
  } opc_ctrl_t;

  // event and status layout: bit 1 overflow, bit 0 capture
  typedef struct packed {
    logic ovf;
    logic cap;
  } opc_evt_t;

  typedef enum logic [1:0] {
    OPC_SRC_FAST,
    OPC_SRC_DIV2,
    OPC_SRC_DIV4,
    OPC_SRC_DIV8
  } opc_src_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic [31:0] wdata;
  } opc_apb_req_t;

endpackage

// >>> verilog/opc_sync_edge.sv
`timescale 1ns/1ps
`default_nettype none
module opc_sync_edge (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic rise
);

  logic meta_ff;
  logic sync_ff;
  logic last_ff;
  logic rise_ff;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
      rise_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
      rise_ff <= sync_ff & ~last_ff;
    end
  end

  assign rise = rise_ff;

endmodule
`default_nettype wire

// >>> verilog/opc_div_edge.sv
`timescale 1ns/1ps
`default_nettype none
`include "opc_consts.svh"
module opc_div_edge #(
  parameter int DIV = `OPC_SLOW_DIV
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic tick,
  output logic div_level,
  output logic div_rise,
  output logic div_fall
);

  localparam int HALF = DIV / 2;
  localparam int CW = (HALF > 1) ? $clog2(HALF) : 1;
  localparam logic [CW-1:0] LAST = CW'(HALF - 1);

  logic [CW-1:0] cnt_ff;
  logic level_ff;
  logic rise_ff;
  logic fall_ff;
  wire flip = tick && (cnt_ff == LAST);

  // one period of the divided clock spans DIV input rising edges
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      cnt_ff <= '0;
      level_ff <= 1'b0;
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
    end
    else
    begin
      if (tick)
        cnt_ff <= flip ? '0 : cnt_ff + 1'b1;
      if (flip)
        level_ff <= ~level_ff;
      rise_ff <= flip & ~level_ff;
      fall_ff <= flip & level_ff;
    end
  end

  assign div_level = level_ff;
  assign div_rise = rise_ff;
  assign div_fall = fall_ff;

endmodule
`default_nettype wire

// >>> verilog/opc_period_capture_timer.sv
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "opc_consts.svh"
module opc_period_capture_timer #(
  parameter int CNT_W = `OPC_CNT_W,
  parameter int SLOW_DIV = `OPC_SLOW_DIV
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic slow_osc_clock,
  output logic slow_osc_div_clock,
  output logic irq
);

  localparam logic [CNT_W-1:0] CNT_MAX = '1;

  // bus request gathered in one carrier
  opc_pkg::opc_apb_req_t req;
  assign req.addr = paddr;
  assign req.wr = pwrite;
  assign req.wdata = pwdata;

  // registers
  opc_pkg::opc_ctrl_t ctrl_ff;
  opc_pkg::opc_evt_t status_ff;
  opc_pkg::opc_evt_t irq_en_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] cap_cur_ff;
  logic [CNT_W-1:0] cap_prev_ff;
  logic [CNT_W-1:0] cap_num_ff;
  logic [CNT_W-1:0] ovf_run_ff;
  logic [CNT_W-1:0] ovf_snap_ff;
  logic [`OPC_PRE_W-1:0] pre_ff;
  logic [31:0] prdata_ff;

  // next values
  opc_pkg::opc_evt_t nxt_status;
  logic [CNT_W-1:0] nxt_cnt;
  logic [CNT_W-1:0] nxt_ovf_run;
  logic [31:0] nxt_prdata;

  // ---------------- bus decode ----------------
  wire setup_ph = psel & ~penable;
  wire access_ph = psel & penable;
  wire hit_ctrl = (req.addr == `OPC_ADDR_CTRL);
  wire hit_status = (req.addr == `OPC_ADDR_STATUS);
  wire hit_irq_en = (req.addr == `OPC_ADDR_IRQ_EN);
  wire hit_count = (req.addr == `OPC_ADDR_COUNT);
  wire hit_cur = (req.addr == `OPC_ADDR_CAP_CUR);
  wire hit_prev = (req.addr == `OPC_ADDR_CAP_PREV);
  wire hit_num = (req.addr == `OPC_ADDR_CAP_NUM);
  wire hit_snap = (req.addr == `OPC_ADDR_OVF_SNAP);
  wire hit_any = hit_ctrl | hit_status | hit_irq_en | hit_count
               | hit_cur | hit_prev | hit_num | hit_snap;

  wire wr_ok = access_ph & req.wr & hit_any;
  wire wr_ctrl = wr_ok & hit_ctrl;
  wire wr_status = wr_ok & hit_status;
  wire wr_irq_en = wr_ok & hit_irq_en;
  wire wr_count = wr_ok & hit_count;

  // zero wait states; capture registers ignore writes silently
  assign pready = 1'b1;
  assign pslverr = access_ph & ~hit_any;
  assign prdata = prdata_ff;

  // ---------------- capture trigger path ----------------
  logic slow_rise;
  logic div_level;
  logic div_rise;
  logic div_fall;

  opc_sync_edge u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(slow_osc_clock),
    .rise(slow_rise)
  );

  // divide synced slow clock edges down to the capture trigger
  opc_div_edge #(
    .DIV(SLOW_DIV)
  ) u_div (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick(slow_rise),
    .div_level(div_level),
    .div_rise(div_rise),
    .div_fall(div_fall)
  );

  assign slow_osc_div_clock = div_level;

  // rising edge unless falling is picked
  wire edge_hit = ctrl_ff.edge_fall ? div_fall : div_rise; // see RULE7
  wire cap_ev = ctrl_ff.run & edge_hit; // see RULE1

  // ---------------- count source ----------------
  // mclk stands in for the fast oscillator; slower sources are enable pulses
  wire src_fast = (ctrl_ff.src == opc_pkg::OPC_SRC_FAST);
  wire src_div2 = (ctrl_ff.src == opc_pkg::OPC_SRC_DIV2);
  wire src_div4 = (ctrl_ff.src == opc_pkg::OPC_SRC_DIV4);
  wire src_div8 = (ctrl_ff.src == opc_pkg::OPC_SRC_DIV8);
  wire pre_t2 = pre_ff[0];
  wire pre_t4 = &pre_ff[1:0];
  wire pre_t8 = &pre_ff[2:0];
  wire src_tick = src_fast // see RULE6
                | (src_div2 & pre_t2)
                | (src_div4 & pre_t4)
                | (src_div8 & pre_t8);
  wire cnt_tick = ctrl_ff.run & src_tick;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      pre_ff <= '0;
    else if (!ctrl_ff.run)
      pre_ff <= '0;
    else
      pre_ff <= pre_ff + 1'b1;
  end

  // ---------------- counter ----------------
  // a bus load replaces the count, so no wrap happens in that cycle
  wire wrap_ev = cnt_tick & ~wr_count & (cnt_ff == CNT_MAX); // see RULE8
  wire cap_clear = cap_ev & ctrl_ff.clr_on_cap;

  // a bus load wins over counting; clearing on capture is optional
  always_comb
  begin
    nxt_cnt = cnt_ff;
    if (wr_count)
      nxt_cnt = req.wdata[CNT_W-1:0];
    else if (cap_clear)
      nxt_cnt = '0;
    else if (cnt_tick)
      nxt_cnt = cnt_ff + 1'b1; // see RULE8
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      cnt_ff <= '0;
    else
      cnt_ff <= nxt_cnt;
  end

  // ---------------- capture registers ----------------
  // the value taken is the count before this cycle's increment
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      cap_cur_ff <= '0;
      cap_prev_ff <= '0;
    end
    else if (cap_ev)
    begin
      cap_cur_ff <= cnt_ff; // see RULE5
      if (ctrl_ff.buf_en)
        cap_prev_ff <= cap_cur_ff; // see RULE5
    end
  end

  // capture tally saturates rather than wrapping
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      cap_num_ff <= '0;
    else if (cap_ev && (cap_num_ff != CNT_MAX))
      cap_num_ff <= cap_num_ff + 1'b1;
  end

  // overflows since the last capture, frozen at each capture
  always_comb
  begin
    nxt_ovf_run = ovf_run_ff;
    if (wrap_ev && (ovf_run_ff != CNT_MAX))
      nxt_ovf_run = ovf_run_ff + 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ovf_run_ff <= '0;
      ovf_snap_ff <= '0;
    end
    else if (cap_ev)
    begin
      ovf_snap_ff <= nxt_ovf_run;
      ovf_run_ff <= '0;
    end
    else
      ovf_run_ff <= nxt_ovf_run;
  end

  // ---------------- status and interrupt ----------------
  opc_pkg::opc_evt_t evt;
  opc_pkg::opc_evt_t w1c;
  assign evt.cap = cap_ev; // see RULE4
  assign evt.ovf = wrap_ev; // see RULE3
  assign w1c = wr_status ? req.wdata[`OPC_EVT_W-1:0] : `OPC_EVT_RST;

  // a new event in the clearing cycle survives the clear
  assign nxt_status = (status_ff & ~w1c) | evt;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      status_ff <= `OPC_EVT_RST;
    else
      status_ff <= nxt_status;
  end

  // level output straight from the flags and enables
  assign irq = |(status_ff & irq_en_ff); // see RULE2

  // ---------------- software registers ----------------
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ctrl_ff <= `OPC_CTRL_RST;
      irq_en_ff <= `OPC_EVT_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_ff <= req.wdata[`OPC_CTRL_W-1:0];
      if (wr_irq_en)
        irq_en_ff <= req.wdata[`OPC_EVT_W-1:0]; // see RULE7
    end
  end

  // ---------------- read path ----------------
  // sampled in setup so data sits still through the access phase
  wire [31:0] rd_ctrl = {{(32 - `OPC_CTRL_W){1'b0}}, ctrl_ff};
  wire [31:0] rd_status = {{(32 - `OPC_EVT_W){1'b0}}, status_ff};
  wire [31:0] rd_irq_en = {{(32 - `OPC_EVT_W){1'b0}}, irq_en_ff};
  wire [31:0] rd_count = {{(32 - CNT_W){1'b0}}, cnt_ff};
  wire [31:0] rd_cur = {{(32 - CNT_W){1'b0}}, cap_cur_ff};
  wire [31:0] rd_prev = {{(32 - CNT_W){1'b0}}, cap_prev_ff};
  wire [31:0] rd_num = {{(32 - CNT_W){1'b0}}, cap_num_ff};
  wire [31:0] rd_snap = {{(32 - CNT_W){1'b0}}, ovf_snap_ff};

  always_comb
  begin
    nxt_prdata = 32'h0000_0000;
    if (hit_ctrl)
      nxt_prdata = rd_ctrl;
    if (hit_status)
      nxt_prdata = rd_status;
    if (hit_irq_en)
      nxt_prdata = rd_irq_en;
    if (hit_count)
      nxt_prdata = rd_count;
    if (hit_cur)
      nxt_prdata = rd_cur;
    if (hit_prev)
      nxt_prdata = rd_prev;
    if (hit_num)
      nxt_prdata = rd_num;
    if (hit_snap)
      nxt_prdata = rd_snap;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      prdata_ff <= 32'h0000_0000;
    else if (setup_ph && !req.wr)
      prdata_ff <= nxt_prdata;
  end

endmodule
`default_nettype wire

// >>> bench/opc_timer_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module opc_timer_asserts #(
  parameter int CNT_W = 16,
  parameter int SLOW_DIV = 128
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic slow_osc_clock,
  input wire logic slow_osc_div_clock,
  input wire logic irq
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  sequence s_acc;
    psel && penable;
  endsequence
  property p_rdy;
    pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("pready low");
  property p_err;
    s_acc ##0 (paddr > 8'h1C) |-> pslverr;
  endproperty
  a_err: assert property (p_err) else $error("no error on unmapped access");
  property p_noerr;
    !(psel && penable) || (paddr <= 8'h1C && paddr[1:0] == 2'h0) |-> !pslverr;
  endproperty
  a_noerr: assert property (p_noerr) else $error("spurious slave error");
  property p_prd;
    !(psel && !penable && !pwrite) |=> $stable(prdata);
  endproperty
  a_prd: assert property (p_prd) else $error("read data moved without read setup");
  property p_div_hold;
    $changed(slow_osc_div_clock) |=> $stable(slow_osc_div_clock) [*8];
  endproperty
  a_div_hold: assert property (p_div_hold) else $error("divided clock too fast");
  property p_div_rst;
    disable iff (1'b0) !rst_n |=> !slow_osc_div_clock;
  endproperty
  a_div_rst: assert property (p_div_rst) else $error("divided clock high after reset");
  property p_irq_rst;
    disable iff (1'b0) !rst_n |=> !irq;
  endproperty
  a_irq_rst: assert property (p_irq_rst) else $error("irq high after reset");
  // flags are sticky, so only a register write may drop the request
  property p_irq_fall;
    $fell(irq) && $past(rst_n) |-> $past(psel && penable && pwrite);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
endmodule
bind opc_period_capture_timer opc_timer_asserts #(.CNT_W(CNT_W), .SLOW_DIV(SLOW_DIV)) u_chk (
  .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .slow_osc_clock(slow_osc_clock), .slow_osc_div_clock(slow_osc_div_clock), .irq(irq));
`default_nettype wire

// >>> bench/opc_slow_osc.sv
`timescale 1ns/1ps
`default_nettype none
module opc_slow_osc (
  input wire logic [7:0] half_cyc,
  output logic slow_osc_clock
);
  // free running; phase kept off the mclk edges so sync latency stays steady
  initial
  begin
    slow_osc_clock = 1'b0;
    #7;
    forever
    begin
      #(half_cyc * 40);
      slow_osc_clock = ~slow_osc_clock;
    end
  end
endmodule
`default_nettype wire

// >>> bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int DIV = 4;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [7:0] half_cyc = 8'h06;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic irq;
  logic slow_osc_clock;
  logic slow_osc_div_clock;
  logic err;
  logic [31:0] q, c1, c2;
  logic [31:0] lfsr_ff = 32'h0000_d277;
  int fails = 0;
  int checks = 0;
  always #20 mclk = ~mclk;
  opc_slow_osc u_opc_slow_osc (.half_cyc(half_cyc), .slow_osc_clock(slow_osc_clock));
  opc_period_capture_timer #(.CNT_W(8), .SLOW_DIV(DIV)) u_opc_period_capture_timer (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .slow_osc_clock(slow_osc_clock), .slow_osc_div_clock(slow_osc_div_clock), .irq(irq));
  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // counter runs on mclk, so a capture interval is DIV slow periods in mclk ticks
  function automatic logic [31:0] exp_period(input int h);
    return 32'(DIV * 2 * h) & 32'h0000_00ff;
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task close_out;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
      @(posedge mclk);
    while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // capture lands one edge after the divided clock rises; extra edges give margin
  task wait_cap;
    @(posedge slow_osc_div_clock);
    repeat (3) @(posedge mclk);
  endtask
  task irq_is(input logic v);
    @(negedge mclk);
    chk({31'h0000_0000, irq}, {31'h0000_0000, v});
  endtask
  initial
  begin
    repeat (20000) @(posedge mclk);
    fails++;
    close_out();
  end
  initial
  begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b0, 8'(i * 4), 32'h0000_0000);
      chk(q, 32'h0000_0000);
    end
    apb(1'b1, 8'h40, 32'hffff_ffff);
    chk({31'h0000_0000, err}, 32'h0000_0001);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    $display("end of reset test");
    for (int i = 0; i < 4; i++)
    begin
      lfsr_ff = lfsr_step(lfsr_ff);
      apb(1'b1, 8'h00, 32'(i % 2));
      apb(1'b1, 8'h0C, lfsr_ff & 32'h0000_00ff);
      apb(1'b0, 8'h0C, 32'h0000_0000);
      chk(q, (lfsr_ff + 32'(i % 2)) & 32'h0000_00ff);
    end
    $display("end of count test");
    apb(1'b1, 8'h08, 32'h0000_0002);
    apb(1'b1, 8'h0C, 32'h0000_0000);
    apb(1'b1, 8'h04, 32'h0000_0003);
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk(q & 32'h0000_0002, 32'h0000_0000);
    irq_is(1'b0);
    apb(1'b1, 8'h0C, 32'h0000_00ff);
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk(q & 32'h0000_0002, 32'h0000_0002);
    irq_is(1'b1);
    apb(1'b1, 8'h04, 32'h0000_0002);
    irq_is(1'b0);
    $display("end of overflow test");
    apb(1'b1, 8'h08, 32'h0000_0000);
    apb(1'b1, 8'h00, 32'h0000_0021);
    for (int k = 0; k < 2; k++)
    begin
      half_cyc <= 8'(6 + 4 * k);
      // let one capture pass so the measured interval sees only the new period
      wait_cap();
      apb(1'b1, 8'h04, 32'h0000_0001);
      wait_cap();
      irq_is(1'b0);
      apb(1'b0, 8'h04, 32'h0000_0000);
      chk(q & 32'h0000_0001, 32'h0000_0001);
      apb(1'b1, 8'h08, 32'h0000_0001);
      irq_is(1'b1);
      apb(1'b1, 8'h04, 32'h0000_0001);
      irq_is(1'b0);
      apb(1'b0, 8'h10, 32'h0000_0000);
      c1 = q;
      wait_cap();
      apb(1'b0, 8'h10, 32'h0000_0000);
      c2 = q;
      apb(1'b0, 8'h14, 32'h0000_0000);
      chk(q, c1);
      chk((c2 - c1) & 32'h0000_00ff, exp_period(6 + 4 * k));
      apb(1'b1, 8'h08, 32'h0000_0000);
    end
    $display("end of capture test");
    apb(1'b1, 8'h00, 32'h0000_0031);
    wait_cap();
    wait_cap();
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk(q, exp_period(10) - 32'h0000_0001);
    $display("end of clear test");
    close_out();
  end
endmodule
`default_nettype wire
